// >>> core/rn_regs.sv
// Control registers and enable logic of regulator nine, AHB-Lite slave
`timescale 1ns/100ps
`default_nettype none

module rn_regs
  import rn_pkg::*;
(
  input  wire logic        core_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic      [31:0] hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o,
  input  wire logic        seq_slot_stb_i,
  input  wire logic        seq_sleep_i,
  input  wire logic [2:0]  seq_slot_i,
  input  wire logic        uv_fault_i,
  input  wire logic        hw_en1_i,
  input  wire logic        hw_en2_i,
  input  wire logic        hw_ctrl1_i,
  input  wire logic        hw_ctrl2_i,
  output var rn_out_s      reg_out_o,
  output logic             device_reset_o,
  output logic             irq_o
);

  localparam int PIN_N = 5;

  // ==========================================================================
  // Pin synchronisers
  // ==========================================================================
  logic [PIN_N-1:0] pin_raw;
  logic [PIN_N-1:0] s1_r;
  logic [PIN_N-1:0] s2_r;
  logic [PIN_N-1:0] s3_r;
  logic [PIN_N-1:0] pin_f_r;
  logic [PIN_N-1:0] pin_f_nxt;
  logic             uv_f;
  logic             hwe1;
  logic             hwe2;
  logic             hwc1;
  logic             hwc2;
  logic             uv_prev_r;
  logic             uv_evt;

  assign pin_raw   = {hw_ctrl2_i, hw_ctrl1_i, hw_en2_i, hw_en1_i, uv_fault_i};
  // A change is taken once the second and third stages agree
  assign pin_f_nxt = (~(s2_r ^ s3_r) & s3_r) | ((s2_r ^ s3_r) & pin_f_r);
  assign {hwc2, hwc1, hwe2, hwe1, uv_f} = pin_f_r;
  assign uv_evt    = uv_f & ~uv_prev_r;

  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      s1_r      <= '0;
      s2_r      <= '0;
      s3_r      <= '0;
      pin_f_r   <= '0;
      uv_prev_r <= 1'b0;
    end
    else
    begin
      s1_r      <= pin_raw;
      s2_r      <= s1_r;
      s3_r      <= s2_r;
      pin_f_r   <= pin_f_nxt;
      uv_prev_r <= uv_f;
    end
  end

  // ==========================================================================
  // AHB-Lite slave: writes zero-wait, reads one wait state
  // ==========================================================================
  logic        ap_take;
  logic        dp_wr_r;
  logic        dp_rd_r;
  logic        rd_wait_r;
  logic [29:0] dp_addr_r;
  logic [31:0] hrdata_r;
  logic [31:0] rd_mux;
  logic        wr_go;

  rn_ctl_s     ctl_r;
  rn_state_s   on_r;
  rn_state_s   slp_r;
  logic [IRQ_N-1:0] irq_sts_r;
  logic [IRQ_N-1:0] irq_mask_r;
  logic [IRQ_N-1:0] irq_evt;
  logic [15:0] state_word;

  function automatic logic hit(input logic [29:0] a, input logic [15:0] idx);
    hit = (a == {14'h0000, idx});
  endfunction

  function automatic logic [15:0] pack_st(input rn_state_s s);
    pack_st = '0;
    pack_st[POS_SLOT +: 3]  = s.slot;
    pack_st[POS_PMODE]      = s.pmode;
    pack_st[POS_VCODE +: 5] = s.vcode;
  endfunction

  function automatic rn_state_s unpack_st(input logic [31:0] d);
    unpack_st.slot  = d[POS_SLOT +: 3];
    unpack_st.pmode = d[POS_PMODE];
    unpack_st.vcode = d[POS_VCODE +: 5];
  endfunction

  assign ap_take     = hsel_i & hready_i & htrans_i[1];
  assign hreadyout_o = ~(dp_rd_r & ~rd_wait_r);
  assign hresp_o     = 1'b0;
  assign hrdata_o    = hrdata_r;
  assign wr_go       = dp_wr_r;

  always_comb
  begin
    rd_mux = '0;
    if (hit(dp_addr_r, IDX_FAULT_HWC))
    begin
      rd_mux[POS_UV_ACT +: 2]  = ctl_r.uv_act;
      rd_mux[POS_HWC_SRC +: 2] = ctl_r.hwc_src;
      rd_mux[POS_HWC_VSEL]     = ctl_r.hwc_vsel;
      rd_mux[POS_HWC_MODE +: 2] = ctl_r.hwc_mode;
      rd_mux[POS_FLOAT]        = ctl_r.flt;
      rd_mux[POS_SWITCH]       = ctl_r.swi;
    end
    else if (hit(dp_addr_r, IDX_ON_STATE))
      rd_mux[15:0] = pack_st(on_r);
    else if (hit(dp_addr_r, IDX_SLEEP_ST))
      rd_mux[15:0] = pack_st(slp_r);
    else if (hit(dp_addr_r, IDX_IRQ_STS))
      rd_mux[IRQ_N-1:0] = irq_sts_r;
    else if (hit(dp_addr_r, IDX_IRQ_MASK))
      rd_mux[IRQ_N-1:0] = irq_mask_r;
    else if (hit(dp_addr_r, IDX_STATE))
      rd_mux[15:0] = state_word;
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      dp_wr_r   <= 1'b0;
      dp_rd_r   <= 1'b0;
      rd_wait_r <= 1'b0;
      dp_addr_r <= '0;
      hrdata_r  <= '0;
    end
    else if (hreadyout_o)
    begin
      dp_wr_r   <= ap_take & hwrite_i & (hsize_i == 3'h2);
      dp_rd_r   <= ap_take & ~hwrite_i;
      rd_wait_r <= 1'b0;
      if (ap_take)
        dp_addr_r <= haddr_i[31:2];
    end
    else
    begin
      rd_wait_r <= 1'b1;
      hrdata_r  <= rd_mux;
    end
  end

  // ==========================================================================
  // Setting registers; writes only store values
  // ==========================================================================
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      ctl_r      <= CTL_RST;
      on_r       <= '0;
      slp_r      <= '{SLOT_NONE, SLP_MODE_RST, 5'h00};
      irq_mask_r <= '0;
    end
    else if (wr_go)
    begin
      if (hit(dp_addr_r, IDX_FAULT_HWC))
      begin
        ctl_r.uv_act   <= hwdata_i[POS_UV_ACT +: 2];
        ctl_r.hwc_src  <= hwdata_i[POS_HWC_SRC +: 2];
        ctl_r.hwc_vsel <= hwdata_i[POS_HWC_VSEL];
        ctl_r.hwc_mode <= hwdata_i[POS_HWC_MODE +: 2];
        ctl_r.flt      <= hwdata_i[POS_FLOAT];
        ctl_r.swi      <= hwdata_i[POS_SWITCH];
      end
      if (hit(dp_addr_r, IDX_ON_STATE))
        on_r <= unpack_st(hwdata_i);
      if (hit(dp_addr_r, IDX_SLEEP_ST))
        slp_r <= unpack_st(hwdata_i);
      if (hit(dp_addr_r, IDX_IRQ_MASK))
        irq_mask_r <= hwdata_i[IRQ_N-1:0];
    end
  end

  // ==========================================================================
  // Timeslot sequencing
  // ==========================================================================
  logic       hw_assigned;
  logic       startup_ev;
  logic       sleep_ev;
  logic       slp_disable_code;
  logic [2:0] slp_slot;
  logic [2:0] wake_slot;
  logic       slot_en_r;
  logic       sleep_r;
  logic       shut_r;

  // Sleep slot code to timeslot: 000/001 -> 5 ... 101 -> 1, 110 -> 3, 111 -> 1
  function automatic logic [2:0] sleep_slot_of(input logic [2:0] c);
    case (c)
      3'h0:    sleep_slot_of = 3'h5;
      3'h6:    sleep_slot_of = 3'h3;
      3'h7:    sleep_slot_of = 3'h1;
      default: sleep_slot_of = 3'(3'h6 - c);
    endcase
  endfunction

  function automatic logic slot_code(input logic [2:0] c);
    slot_code = (c != SLOT_NONE) && (c <= SLOT_LAST);
  endfunction

  assign hw_assigned = (on_r.slot == SLOT_HWE1) | (on_r.slot == SLOT_HWE2);
  assign startup_ev  = seq_slot_stb_i & ~seq_sleep_i;
  assign sleep_ev    = seq_slot_stb_i & seq_sleep_i;
  assign slp_disable_code = slot_code(slp_r.slot);
  assign slp_slot    = sleep_slot_of(slp_r.slot);
  assign wake_slot   = slot_code(on_r.slot) ? on_r.slot : SLOT_FIRST;

  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      slot_en_r <= 1'b0;
    else if (startup_ev && !hw_assigned && slot_code(on_r.slot)
             && seq_slot_i == on_r.slot)
      slot_en_r <= 1'b1;
    else if (sleep_ev && !hw_assigned && slp_disable_code
             && seq_slot_i == slp_slot)
      slot_en_r <= 1'b0;
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      sleep_r <= 1'b0;
    else if (sleep_ev && seq_slot_i == slp_slot
             && (hw_assigned || !slp_disable_code))
      sleep_r <= 1'b1;
    else if (startup_ev && seq_slot_i == wake_slot)
      sleep_r <= 1'b0;
  end

  // Shutdown by undervoltage holds until the next start-up sequence
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      shut_r <= 1'b0;
    else if (uv_evt && ctl_r.uv_act == ACT_SHUTDOWN)
      shut_r <= 1'b1;
    else if (startup_ev && seq_slot_i == SLOT_FIRST)
      shut_r <= 1'b0;
  end

  // ==========================================================================
  // Output composition
  // ==========================================================================
  logic       hwc_act;
  logic       hw_en_sel;
  logic       en_base;
  logic       en_final;
  logic [4:0] vcode;
  logic       low_power;
  rn_out_s    out_r;
  logic       dev_rst_r;

  always_comb
  begin
    unique case (ctl_r.hwc_src)
      2'h0: hwc_act = 1'b0;
      2'h1: hwc_act = hwc1;
      2'h2: hwc_act = hwc2;
      2'h3: hwc_act = hwc1 | hwc2;
    endcase
  end

  assign hw_en_sel = (on_r.slot == SLOT_HWE1) ? hwe1 : hwe2;
  assign en_base   = hw_assigned ? hw_en_sel : slot_en_r;
  assign en_final  = en_base & ~shut_r
                     & ~(hwc_act & (ctl_r.hwc_mode == HMODE_OFF));

  always_comb
  begin
    if (hwc_act)
    begin
      vcode     = ctl_r.hwc_vsel ? slp_r.vcode : on_r.vcode;
      low_power = (ctl_r.hwc_mode == HMODE_ONMODE) ? on_r.pmode
                                                   : 1'b1;
    end
    else if (sleep_r)
    begin
      vcode     = slp_r.vcode;
      low_power = slp_r.pmode;
    end
    else
    begin
      vcode     = on_r.vcode;
      low_power = on_r.pmode;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      out_r     <= '0;
      dev_rst_r <= 1'b0;
    end
    else
    begin
      out_r.enable      <= en_final;
      out_r.discharge   <= ~en_final & ~ctl_r.flt;
      out_r.low_power   <= low_power;
      out_r.switch_mode <= ctl_r.swi;
      out_r.vcode       <= vcode;
      out_r.mv          <= code_to_mv(vcode);
      dev_rst_r         <= uv_evt && ctl_r.uv_act == ACT_RESET;
    end
  end

  assign reg_out_o      = out_r;
  assign device_reset_o = dev_rst_r;

  always_comb
  begin
    state_word = '0;
    state_word[POS_ST_EN]       = out_r.enable;
    state_word[POS_ST_LP]       = out_r.low_power;
    state_word[POS_ST_HWA]      = hw_assigned;
    state_word[POS_ST_HWC]      = hwc_act;
    state_word[POS_ST_SHUT]     = shut_r;
    state_word[POS_ST_SLEEP]    = sleep_r;
    state_word[POS_ST_VCODE +: 5] = out_r.vcode;
  end

  // ==========================================================================
  // Interrupts: sticky status, write one to clear, set wins
  // ==========================================================================
  assign irq_evt[IRQ_UV]     = uv_evt;
  assign irq_evt[IRQ_EN_ON]  = en_final & ~out_r.enable;
  assign irq_evt[IRQ_EN_OFF] = ~en_final & out_r.enable;

  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      irq_sts_r <= '0;
    else if (wr_go && hit(dp_addr_r, IDX_IRQ_STS))
      irq_sts_r <= (irq_sts_r & ~hwdata_i[IRQ_N-1:0]) | irq_evt;
    else
      irq_sts_r <= irq_sts_r | irq_evt;
  end

  assign irq_o = |(irq_sts_r & irq_mask_r);

  // ==========================================================================
  // Assertions
  // ==========================================================================
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);

  AST_UV_RESET: assert property (
    uv_evt && ctl_r.uv_act == ACT_RESET |=> device_reset_o ##1 !device_reset_o)
    else $error("device reset not pulsed on undervoltage");

  AST_UV_SHUT: assert property (
    uv_evt && ctl_r.uv_act == ACT_SHUTDOWN && !startup_ev
    |=> shut_r ##1 !reg_out_o.enable)
    else $error("regulator not shut down on undervoltage");

  AST_UV_IGNORE: assert property (
    uv_evt && ctl_r.uv_act == ACT_IGNORE |=> !device_reset_o)
    else $error("ignored fault caused a reset");

  AST_UV_IRQ: assert property (
    uv_evt |=> irq_sts_r[IRQ_UV])
    else $error("undervoltage status not set");

  AST_HWC_VOLT: assert property (
    hwc_act && !ctl_r.hwc_vsel |=> reg_out_o.vcode == $past(on_r.vcode))
    else $error("hardware control voltage not from ON code");

  AST_HWC_OFF: assert property (
    hwc_act && ctl_r.hwc_mode == HMODE_OFF |=> !reg_out_o.enable)
    else $error("hardware mode off left regulator on");

  AST_DISCHARGE: assert property (
    reg_out_o.discharge |-> !reg_out_o.enable)
    else $error("discharge while enabled");

  AST_SLOT_ON: assert property (
    startup_ev && !hw_assigned && slot_code(on_r.slot)
    && seq_slot_i == on_r.slot && !shut_r && !hwc_act
    |=> slot_en_r ##1 reg_out_o.enable)
    else $error("regulator not enabled in its timeslot");

  AST_HW_EN: assert property (
    on_r.slot == SLOT_HWE1 && hwe1 && !shut_r && !hwc_act
    |=> reg_out_o.enable)
    else $error("hardware enable 1 ignored");

  AST_SLEEP_OFF: assert property (
    sleep_ev && !hw_assigned && slp_r.slot == 3'h1 && seq_slot_i == 3'h5
    |=> !slot_en_r)
    else $error("regulator not disabled in sleep timeslot 5");

  AST_MV_TOP: assert property (
    reg_out_o.vcode == 5'h1f |-> reg_out_o.mv == 12'hdac)
    else $error("top voltage code not 3.50V");

  AST_WRITE_ONLY: assert property (
    wr_go && !seq_slot_stb_i |=> $stable(slot_en_r))
    else $error("register write changed enable state");

endmodule

`default_nettype wire

// >>> core/rn_pkg.sv
// Package of register map, field layouts and types for the regulator block
package rn_pkg;

  // ==========================================================================
  // Register indices; byte address is four times the index
  // ==========================================================================
  localparam logic [15:0] IDX_FAULT_HWC  = 16'h4080;
  localparam logic [15:0] IDX_ON_STATE   = 16'h4081;
  localparam logic [15:0] IDX_SLEEP_ST   = 16'h4082;
  localparam logic [15:0] IDX_IRQ_STS    = 16'h4088;
  localparam logic [15:0] IDX_IRQ_MASK   = 16'h4089;
  localparam logic [15:0] IDX_STATE      = 16'h408a;

  // ==========================================================================
  // Field positions
  // ==========================================================================
  localparam int POS_UV_ACT    = 14;
  localparam int POS_HWC_SRC   = 11;
  localparam int POS_HWC_VSEL  = 10;
  localparam int POS_HWC_MODE  = 8;
  localparam int POS_FLOAT     = 7;
  localparam int POS_SWITCH    = 6;
  localparam int POS_SLOT      = 13;
  localparam int POS_PMODE     = 8;
  localparam int POS_VCODE     = 0;
  localparam int POS_ST_EN     = 0;
  localparam int POS_ST_LP     = 1;
  localparam int POS_ST_HWA    = 2;
  localparam int POS_ST_HWC    = 3;
  localparam int POS_ST_SHUT   = 4;
  localparam int POS_ST_SLEEP  = 5;
  localparam int POS_ST_VCODE  = 8;
  localparam int IRQ_UV        = 0;
  localparam int IRQ_EN_ON     = 1;
  localparam int IRQ_EN_OFF    = 2;
  localparam int IRQ_N         = 3;

  // ==========================================================================
  // Codes and reset values
  // ==========================================================================
  localparam logic [1:0] ACT_IGNORE   = 2'h0;
  localparam logic [1:0] ACT_SHUTDOWN = 2'h1;
  localparam logic [1:0] ACT_RESET    = 2'h2;
  localparam logic [1:0] HMODE_OFF    = 2'h1;
  localparam logic [1:0] HMODE_ONMODE = 2'h3;
  localparam logic [1:0] HMODE_RST    = 2'h2;
  localparam logic [2:0] SLOT_NONE    = 3'h0;
  localparam logic [2:0] SLOT_LAST    = 3'h5;
  localparam logic [2:0] SLOT_HWE1    = 3'h6;
  localparam logic [2:0] SLOT_HWE2    = 3'h7;
  localparam logic [2:0] SLOT_FIRST   = 3'h1;
  localparam logic       SLP_MODE_RST = 1'h1;
  localparam logic [4:0] FINE_LAST    = 5'h0c;
  localparam logic [11:0] MV_BASE     = 12'h3e8;
  localparam logic [11:0] MV_COARSE   = 12'h6a4;
  localparam logic [11:0] MV_FINE     = 12'h032;
  localparam logic [11:0] MV_STEP     = 12'h064;

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef struct packed {
    logic [1:0] uv_act;
    logic [1:0] hwc_src;
    logic       hwc_vsel;
    logic [1:0] hwc_mode;
    logic       flt;
    logic       swi;
  } rn_ctl_s;

  typedef struct packed {
    logic [2:0] slot;
    logic       pmode;
    logic [4:0] vcode;
  } rn_state_s;

  typedef struct packed {
    logic        enable;
    logic        discharge;
    logic        low_power;
    logic        switch_mode;
    logic [4:0]  vcode;
    logic [11:0] mv;
  } rn_out_s;

  localparam rn_ctl_s CTL_RST = '{2'h0, 2'h0, 1'h0, HMODE_RST, 1'h0, 1'h0};

  // Voltage code to millivolts: fine steps, then coarse steps
  function automatic logic [11:0] code_to_mv(input logic [4:0] c);
    logic [11:0] cw;
    cw = {7'h00, c};
    if (c <= FINE_LAST)
      code_to_mv = 12'(MV_BASE + 12'(MV_FINE * cw));
    else
      code_to_mv = 12'(MV_COARSE + 12'(MV_STEP * 12'(cw - 12'h00d)));
  endfunction

endpackage

// >>> sim/tb.sv
// Self-checking testbench for the regulator nine register block
`timescale 1ns/100ps
`default_nettype none
module tb
  import rn_pkg::*;
;
  typedef struct {logic [31:0] e; logic [31:0] m; bit rd;} rn_note_s;
  localparam logic [31:0] MON  = 32'h07ff_ffff;
  localparam logic [31:0] MOFF = 32'h07fc_0000;
  localparam logic [6:0] HCS [6] = '{7'h31, 7'h51, 7'h7e, 7'h75, 7'h17, 7'h4a};
  localparam logic [2:0] HXP [6] = '{3'h7, 3'h4, 3'h5, 3'h0, 3'h4, 3'h6};
  logic        core_clk_i = 1'b0;
  logic        rst_n_i    = 1'b0;
  logic        hsel       = 1'b0;
  logic        hwrite     = 1'b0;
  logic [31:0] haddr      = 32'h0;
  logic [31:0] hwdata     = 32'h0;
  logic [1:0]  htrans     = 2'h0;
  logic [2:0]  hsize      = 3'h2;
  logic        stb        = 1'b0;
  logic        slp        = 1'b0;
  logic [2:0]  slot       = 3'h1;
  logic        uv         = 1'b0;
  logic        en1        = 1'b0;
  logic        en2        = 1'b0;
  logic        hc1        = 1'b0;
  logic        hc2        = 1'b0;
  logic        smp        = 1'b0;
  logic        rd_dp      = 1'b0;
  logic [3:0]  rcnt       = 4'h0;
  logic [3:0]  rst_exp    = 4'h0;
  logic        sw_exp     = 1'b0;
  logic [31:0] hrdata;
  logic        hresp;
  logic        hready;
  logic        dev_rst;
  logic        irq;
  rn_out_s     ro;
  logic [31:0] obs;
  logic [31:0] r;
  logic [31:0] v;
  logic [4:0]  c;
  logic [1:0]  act;
  logic        m;
  rn_note_s    q[$];
  rn_note_s    nt;
  int          fails      = 0;
  int          n_tests    = 0;

  rn_regs i_rn_regs (
    .core_clk_i     (core_clk_i),
    .rst_n_i        (rst_n_i),
    .hsel_i         (hsel),
    .haddr_i        (haddr),
    .htrans_i       (htrans),
    .hwrite_i       (hwrite),
    .hsize_i        (hsize),
    .hwdata_i       (hwdata),
    .hready_i       (hready),
    .hrdata_o       (hrdata),
    .hreadyout_o    (hready),
    .hresp_o        (hresp),
    .seq_slot_stb_i (stb),
    .seq_sleep_i    (slp),
    .seq_slot_i     (slot),
    .uv_fault_i     (uv),
    .hw_en1_i       (en1),
    .hw_en2_i       (en2),
    .hw_ctrl1_i     (hc1),
    .hw_ctrl2_i     (hc2),
    .reg_out_o      (ro),
    .device_reset_o (dev_rst),
    .irq_o          (irq)
  );

  always #12.5 core_clk_i = ~core_clk_i;

  assign obs = {5'h0, hresp, ro.switch_mode, rcnt, irq, ro.enable,
                ro.discharge, ro.low_power, ro.vcode, ro.mv};

  // ==========================================================================
  // Output monitor
  // ==========================================================================
  always @(posedge core_clk_i)
  begin
    if (dev_rst === 1'b1)
      rcnt <= rcnt + 4'h1;
    if ((rd_dp && hready === 1'b1) || smp)
    begin
      n_tests++;
      if (q.size() == 0)
      begin
        fails++;
        $display("ERROR result with no expectation");
      end
      else
      begin
        nt = q.pop_front();
        v = nt.rd ? hrdata : obs;
        if (((v ^ nt.e) & nt.m) !== 32'h0)
        begin
          fails++;
          $display("ERROR %s expected %h seen %h",
                   nt.rd ? "hrdata_o" : "reg_out_o", nt.e & nt.m, v & nt.m);
        end
      end
    end
    if (hready === 1'b1)
      rd_dp <= hsel && htrans[1] && !hwrite;
  end

  // ==========================================================================
  // Drivers
  // ==========================================================================
  task automatic bus(input logic w, input logic [15:0] idx,
                     input logic [31:0] d);
    @(posedge core_clk_i);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {14'h0, idx, 2'h0};
    hwrite <= w;
    do @(posedge core_clk_i); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge core_clk_i); while (hready !== 1'b1);
  endtask

  task automatic wr(input logic [15:0] idx, input logic [31:0] d);
    bus(1'b1, idx, d);
  endtask

  task automatic rd(input logic [15:0] idx, input logic [31:0] e,
                    input logic [31:0] mk = 32'hffff_ffff);
    q.push_back('{e, mk, 1'b1});
    bus(1'b0, idx, 32'h0);
  endtask

  task automatic chk(input logic [31:0] e, input logic [31:0] mk);
    q.push_back('{e, mk, 1'b0});
    @(posedge core_clk_i);
    smp <= 1'b1;
    @(posedge core_clk_i);
    smp <= 1'b0;
  endtask

  task automatic ev(input logic s, input logic [2:0] n);
    @(posedge core_clk_i);
    stb  <= 1'b1;
    slp  <= s;
    slot <= n;
    @(posedge core_clk_i);
    stb  <= 1'b0;
    repeat (2) @(posedge core_clk_i);
  endtask

  task automatic wt();
    repeat (8) @(posedge core_clk_i);
  endtask

  function automatic logic [31:0] ex(input logic i, en, dis, lp,
                                     input logic [4:0] k);
    logic [11:0] mv;
    if (k <= 5'h0c)
      mv = 12'(12'h3e8 + 12'h032 * k);
    else
      mv = 12'(12'h6a4 + 12'h064 * (k - 5'h0d));
    return {5'h0, 1'b0, sw_exp, rst_exp, i, en, dis, lp, k, mv};
  endfunction

  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge core_clk_i);
    fails++;
    report_and_stop();
  end

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  initial
  begin
    void'($urandom(32'h3543d35d));
    repeat (10) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    rd(IDX_FAULT_HWC, 32'h0000_0200);
    rd(IDX_ON_STATE, 32'h0);
    rd(IDX_SLEEP_ST, 32'h0000_0100);
    wr(16'h4090, 32'hffff_ffff);
    rd(16'h4090, 32'h0);
    r = $urandom() & 32'h0000_e11f;
    wr(IDX_SLEEP_ST, r);
    rd(IDX_SLEEP_ST, r);
    r = $urandom() & 32'h0000_dfc0;
    wr(IDX_FAULT_HWC, r);
    rd(IDX_FAULT_HWC, r);
    wr(IDX_FAULT_HWC, 32'h0);
    // Start-up slots and sleep disable slots
    for (int s = 1; s <= 5; s++)
    begin
      c = 5'($urandom());
      m = 1'($urandom());
      wr(IDX_ON_STATE, {16'h0, 3'(s), 4'h0, m, 3'h0, c});
      ev(1'b0, 3'(s % 5 + 1));
      chk(ex(0, 0, 1, 0, c), MOFF);
      ev(1'b0, 3'(s));
      chk(ex(0, 1, 0, m, c), MON);
      wr(IDX_SLEEP_ST, {16'h0, 3'(6 - s), 13'h0100});
      ev(1'b1, 3'(s));
      chk(ex(0, 0, 1, 0, c), MOFF);
    end
    wr(IDX_FAULT_HWC, 32'h0000_00c0);
    sw_exp = 1'b1;
    chk(ex(0, 0, 0, 0, c), MOFF);
    wr(IDX_FAULT_HWC, 32'h0);
    sw_exp = 1'b0;
    // Hardware enable inputs
    for (int k = 0; k < 2; k++)
    begin
      wr(IDX_ON_STATE, {16'h0, 3'(6 + k), 13'h0009});
      ev(1'b0, 3'h1);
      en1 <= k[0];
      en2 <= !k[0];
      wt();
      chk(ex(0, 0, 1, 0, 5'h09), MOFF);
      en1 <= 1'b1;
      en2 <= 1'b1;
      wt();
      chk(ex(0, 1, 0, 0, 5'h09), MOFF);
      en1 <= 1'b0;
      en2 <= 1'b0;
      wt();
      chk(ex(0, 0, 1, 0, 5'h09), MOFF);
    end
    // Sleep entry under hardware enable 2, timeslot 4
    en2 <= 1'b1;
    wr(IDX_SLEEP_ST, 32'h0000_411f);
    ev(1'b1, 3'h4);
    wt();
    chk(ex(0, 1, 0, 1, 5'h1f), MON);
    en2 <= 1'b0;
    // Sleep transitions in timeslots 5, 3 and 1
    wr(IDX_ON_STATE, 32'h0000_2005);
    for (int k = 0; k < 3; k++)
    begin
      c = 5'($urandom());
      m = 1'($urandom());
      ev(1'b0, 3'h1);
      wr(IDX_SLEEP_ST, {16'h0, 3'(k == 0 ? 0 : k + 5), 4'h0, m, 3'h0, c});
      ev(1'b1, 3'(5 - 2 * k));
      chk(ex(0, 1, 0, m, c), MON);
    end
    ev(1'b0, 3'h1);
    chk(ex(0, 1, 0, 0, 5'h05), MON);
    rd(IDX_STATE, 32'h0000_0501);
    // Hardware control source, voltage and mode
    for (int k = 0; k < 6; k++)
    begin
      wr(IDX_FAULT_HWC, {16'h0, 3'h0, HCS[k][6:2], 8'h00});
      hc1 <= HCS[k][0];
      hc2 <= HCS[k][1];
      wt();
      chk(ex(0, HXP[k][2], !HXP[k][2], HXP[k][1],
             HXP[k][0] ? c : 5'h05), HXP[k][2] ? MON : MOFF);
      hc1 <= 1'b0;
      hc2 <= 1'b0;
    end
    // Undervoltage actions and their interrupt
    wr(IDX_IRQ_MASK, 32'h1);
    for (int k = 0; k < 4; k++)
    begin
      act = 2'(k == 0 ? 0 : 4 - k);
      wr(IDX_FAULT_HWC, {16'h0, act, 14'h0});
      uv <= 1'b1;
      wt();
      if (act == ACT_RESET)
        rst_exp++;
      chk(ex(1, act != 1, act == 1, 0, 5'h05), MOFF);
      uv <= 1'b0;
      wt();
      rd(IDX_IRQ_STS, 32'h1, 32'h1);
      wr(IDX_IRQ_STS, 32'h7);
      chk(ex(0, act != 1, act == 1, 0, 5'h05), MOFF);
    end
    repeat (4) @(posedge core_clk_i);
    if (q.size() != 0)
      fails++;
    report_and_stop();
  end

endmodule
`default_nettype wire
